// [pmrc_checker.sv]
// pmrc_checker: port-level properties of the power mode and reset block
// assumes: bound to pmrc_top, single clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module pmrc_checker #(
  parameter int WD_TIMEOUT_CYC = pmrc_pkg::PMRC_WD_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // watched pins and controls
  input wire logic reset_pin,
  input wire logic periph_irq,
  input wire logic irq_ack,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic core_reset,
  input wire logic [15:0] pc_load,
  input wire logic [7:0] stack_init,
  input wire logic skip_next,
  input wire logic wake_irq,
  input wire logic ale_out,
  input wire logic prog_store_strobe,
  input wire logic [7:0] port_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==================================================================
  // helper: run of cycles with the reset pin high, saturating
  // a counter stands in for a long repetition the tools would unroll
  logic [3:0] pin_high_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !reset_pin) begin
      pin_high_q <= 4'h0;
    end else if (pin_high_q != 4'hF) begin
      pin_high_q <= pin_high_q + 4'h1;
    end
  end
  // ==================================================================
  // mode outputs
  // strobes high idle
  property p_idle_strobe;
    !cpu_clk_en && periph_clk_en |-> ale_out && prog_store_strobe;
  endproperty
  a_idle_strobe: assert property (p_idle_strobe) else $error("strobe low in idle");
  property p_pdown_gate;
    !periph_clk_en |-> !cpu_clk_en && ale_out == prog_store_strobe;
  endproperty
  a_pdown_gate: assert property (p_pdown_gate) else $error("bad gating in power-down");
  // ports frozen; reset pin excluded since it rewrites the ports
  property p_port_frozen;
    !cpu_clk_en && !$past(cpu_clk_en) && !core_reset && !reset_pin |-> $stable(port_out);
  endproperty
  a_port_frozen: assert property (p_port_frozen) else $error("port moved while halted");
  property p_consts; pc_load == 16'h0000 && stack_init == 8'h07; endproperty
  a_consts: assert property (p_consts) else $error("wrong pc or stack load");
  property p_port_ff; core_reset && reset_pin |-> port_out == 8'hFF; endproperty
  a_port_ff: assert property (p_port_ff) else $error("port not FF in reset");
  // long pin accepted
  // ninth high sample in a row: eight already counted
  property p_pin_reset; reset_pin && pin_high_q == 4'h8 |-> ##[0:2] core_reset; endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("long pin pulse ignored");
  property p_reset_run; core_reset |-> ##[0:1] (cpu_clk_en && periph_clk_en); endproperty
  a_reset_run: assert property (p_reset_run) else $error("clocks stopped after reset");
  property p_wake; wake_irq |-> cpu_clk_en ##1 !wake_irq; endproperty
  a_wake: assert property (p_wake) else $error("bad wake pulse");
  property p_idle_irq;
    !cpu_clk_en && periph_clk_en && periph_irq && !reset_pin |=> wake_irq && cpu_clk_en;
  endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("idle not left on interrupt");
  property p_skip_hold; skip_next && !irq_ack |=> skip_next; endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skip flag dropped early");
  // main scenarios reached
  c_idle_wake: cover property (!cpu_clk_en && periph_irq ##1 wake_irq);
  c_pdown_exit: cover property (!periph_clk_en ##1 periph_clk_en);
  c_skip_clear: cover property (skip_next ##1 !skip_next);
endmodule
`default_nettype wire

// [pmrc_counter.sv]
// pmrc_counter: clearable up counter with a terminal flag
// assumes: one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module pmrc_counter #(
  parameter int WIDTH = 13
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control
  input wire logic clear,
  input wire logic count_en,
  input wire logic [WIDTH-1:0] limit,
  // status
  output logic at_limit
);
  logic [WIDTH-1:0] count_q;

  // =====================================================================
  // counting; sticks at the limit until cleared
  always_ff @(posedge ref_clk) begin
    if (sys_rst || clear) begin
      count_q <= '0;
    end else if (count_en && count_q != limit) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign at_limit = (count_q == limit);
endmodule
`default_nettype wire

// [pmrc_pins_model.sv]
// pmrc_pins_model: external reset source and interrupt pin drivers
// assumes: commands from the bench change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module pmrc_pins_model (
  // clock
  input wire logic ref_clk,
  // commands
  input wire logic rst_go,
  input wire logic [7:0] rst_len,
  input wire logic [1:0] irq_low,
  // pins
  output logic reset_pin,
  output logic ext_irq0_n,
  output logic ext_irq1_n
);
  logic [7:0] left_q = 8'h00;
  always_ff @(posedge ref_clk) begin
    if (rst_go) begin
      left_q <= rst_len;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  // pull-down keeps the reset pin low once released
  assign reset_pin = (left_q != 8'h00);
  assign ext_irq0_n = !irq_low[0];
  assign ext_irq1_n = !irq_low[1];
endmodule
`default_nettype wire

// [pmrc_pkg.sv]
// pmrc_pkg: shared constants for the power mode and reset control block
// assumes: included before every design file that refers to pmrc_pkg
package pmrc_pkg;
  // =====================================================================
  // register map
  localparam logic [7:0] PMRC_ADDR_POWER_CTRL = 8'h87;
  localparam logic [7:0] PMRC_ADDR_WDOG_CTRL = 8'hD8;
  localparam logic [7:0] PMRC_ADDR_TIMED_KEY = 8'hC7;
  localparam logic [7:0] PMRC_ADDR_OPTION = 8'hA2;
  localparam logic [7:0] PMRC_ADDR_IRQ_EN = 8'hA8;
  localparam logic [7:0] PMRC_ADDR_STATUS = 8'hF0;
  // =====================================================================
  // power control fields
  localparam int PMRC_BIT_IDLE = 0;
  localparam int PMRC_BIT_PDOWN = 1;
  // option register field
  localparam int PMRC_BIT_STROBE_HOLD = 2;
  // interrupt enable fields
  localparam int PMRC_BIT_EXT0_EN = 0;
  localparam int PMRC_BIT_EXT1_EN = 2;
  localparam int PMRC_BIT_GLOBAL_EN = 7;
  // =====================================================================
  // watchdog control fields
  localparam int PMRC_BIT_RESTART = 0;
  localparam int PMRC_BIT_WD_EN = 1;
  localparam int PMRC_BIT_WD_RESET_FLAG = 2;
  localparam int PMRC_BIT_WD_IRQ_FLAG = 3;
  localparam int PMRC_BIT_POWER_ON_FLAG = 6;
  localparam logic [7:0] PMRC_WDOG_PROTECT_MASK = 8'h4B;
  localparam logic [7:0] PMRC_WDOG_IMPL_MASK = 8'h4F;
  // =====================================================================
  // reset values
  localparam logic [7:0] PMRC_RST_WDOG_EXT = 8'h00;
  localparam logic [7:0] PMRC_RST_WDOG_WD = 8'h04;
  localparam logic [7:0] PMRC_RST_WDOG_POR = 8'h40;
  localparam logic [7:0] PMRC_RST_PORT = 8'hFF;
  localparam logic [7:0] PMRC_RST_STACK = 8'h07;
  localparam logic [15:0] PMRC_RST_PC = 16'h0000;
  // timed access key bytes
  localparam logic [7:0] PMRC_KEY_FIRST = 8'hAA;
  localparam logic [7:0] PMRC_KEY_SECOND = 8'h55;
  localparam int PMRC_KEY_WINDOW = 3;
  // =====================================================================
  // timing
  localparam int PMRC_CLK_NS = 40;
  localparam int PMRC_RST_MIN_PERIODS = 8;
  localparam int PMRC_RST_MIN_NS = PMRC_RST_MIN_PERIODS * PMRC_CLK_NS;
  localparam int PMRC_RST_MIN_CYC = (PMRC_RST_MIN_NS + PMRC_CLK_NS - 1) / PMRC_CLK_NS;
  localparam int PMRC_WD_GRACE_PERIODS = 512;
  localparam int PMRC_WD_GRACE_NS = PMRC_WD_GRACE_PERIODS * PMRC_CLK_NS;
  localparam int PMRC_WD_GRACE_CYC = PMRC_WD_GRACE_NS / PMRC_CLK_NS;
  localparam int PMRC_WD_TIMEOUT_CYC = 4096;
  // =====================================================================
  // power states
  typedef enum logic [1:0] {
    PMRC_RUN = 2'b00,
    PMRC_IDLE = 2'b01,
    PMRC_PDOWN = 2'b10
  } pmrc_mode_type;
  // reset cause codes
  typedef enum logic [1:0] {
    PMRC_CAUSE_NONE = 2'b00,
    PMRC_CAUSE_EXT = 2'b01,
    PMRC_CAUSE_WD = 2'b10,
    PMRC_CAUSE_POR = 2'b11
  } pmrc_cause_type;
endpackage

// [pmrc_top.sv]
// pmrc_top: idle and power-down sequencing, reset cause tracking, watchdog control
// assumes: register port from the core, reset pin and interrupt pins synchronous to ref_clk
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pmrc_top
  import pmrc_pkg::*;
#(
  parameter int WD_TIMEOUT_CYC = pmrc_pkg::PMRC_WD_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // external pins
  input wire logic reset_pin,
  input wire logic ext_irq0_n,
  input wire logic ext_irq1_n,
  // interrupts from other blocks while idle
  input wire logic periph_irq,
  input wire logic irq_ack,
  // port data from the core
  input wire logic [7:0] port_data,
  // clock gates and core control
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic core_reset,
  output logic [15:0] pc_load,
  output logic [7:0] stack_init,
  output logic skip_next,
  output logic wake_irq,
  // pins
  output logic ale_out,
  output logic prog_store_strobe,
  output logic [7:0] port_out
);
  import pmrc_pkg::*;

  pmrc_mode_type mode_q;
  logic [1:0] power_ctrl_q;
  logic [7:0] watchdog_control_q;
  logic [7:0] option_q;
  logic [7:0] irq_en_q;
  logic [7:0] port_q;
  logic [7:0] reg_rdata_q;
  logic [3:0] rst_cnt_q;
  logic ext_rst_q;
  logic por_done_q;
  logic key_first_q;
  logic [1:0] key_win_q;
  logic grace_q;
  logic wd_rst_q;
  logic core_reset_q;
  logic skip_q;
  logic wake_irq_q;
  logic wr_power_ctrl;
  logic wr_wdog;
  logic timed_ok;
  logic wd_timeout;
  logic grace_end;
  logic ext_wake;
  logic idle_wake;
  logic any_rst;
  pmrc_cause_type cause;

  // =====================================================================
  // decode
  assign wr_power_ctrl = reg_wr && reg_addr == PMRC_ADDR_POWER_CTRL;
  assign wr_wdog = reg_wr && reg_addr == PMRC_ADDR_WDOG_CTRL;
  assign timed_ok = key_win_q != 2'b00;

  // =====================================================================
  // external reset filter
  // eight clock hold
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !reset_pin) begin
      rst_cnt_q <= 4'h0;
      ext_rst_q <= 1'b0;
    end else if (rst_cnt_q != PMRC_RST_MIN_CYC[3:0] - 4'h1) begin
      rst_cnt_q <= rst_cnt_q + 4'h1;
    end else begin
      ext_rst_q <= 1'b1;
    end
  end

  // the first cycle after sys_rst counts as the power-on reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      por_done_q <= 1'b0;
    end else begin
      por_done_q <= 1'b1;
    end
  end

  assign any_rst = ext_rst_q || wd_rst_q;
  always_comb begin
    if (!por_done_q) begin
      cause = PMRC_CAUSE_POR;
    end else if (ext_rst_q) begin
      cause = PMRC_CAUSE_EXT;
    end else if (wd_rst_q) begin
      cause = PMRC_CAUSE_WD;
    end else begin
      cause = PMRC_CAUSE_NONE;
    end
  end

  // =====================================================================
  // timed access key: two key bytes open a short write window
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      key_first_q <= 1'b0;
      key_win_q <= 2'b00;
    end else if (reg_wr && reg_addr == PMRC_ADDR_TIMED_KEY) begin
      key_first_q <= reg_wdata == PMRC_KEY_FIRST;
      key_win_q <= (key_first_q && reg_wdata == PMRC_KEY_SECOND) ?
        PMRC_KEY_WINDOW[1:0] : 2'b00;
    end else if (key_win_q != 2'b00) begin
      key_win_q <= key_win_q - 2'b01;
    end
  end

  // =====================================================================
  // watchdog: timeout counter, then grace before reset
  // keeps counting in idle
  pmrc_counter #(
    .WIDTH(13)
  ) u_timeout (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(any_rst || (wr_wdog && timed_ok && reg_wdata[PMRC_BIT_RESTART])),
    .count_en(mode_q != PMRC_PDOWN),
    .limit(13'(WD_TIMEOUT_CYC)),
    .at_limit(wd_timeout)
  );

  pmrc_counter #(
    .WIDTH(10)
  ) u_grace (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(!grace_q),
    .count_en(grace_q && mode_q != PMRC_PDOWN),
    .limit(10'(PMRC_WD_GRACE_CYC)),
    .at_limit(grace_end)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst || any_rst) begin
      grace_q <= 1'b0;
      wd_rst_q <= 1'b0;
    end else if (wr_wdog && timed_ok && reg_wdata[PMRC_BIT_RESTART]) begin
      grace_q <= 1'b0;
    end else if (wd_timeout && !grace_q) begin
      grace_q <= 1'b1;
    end else if (grace_q && grace_end && watchdog_control_q[PMRC_BIT_WD_EN]) begin
      wd_rst_q <= 1'b1;
    end
  end

  // =====================================================================
  // watchdog control register
  // load by reset source
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      watchdog_control_q <= PMRC_RST_WDOG_POR;
    end else begin
      case (cause)
        PMRC_CAUSE_POR: watchdog_control_q <= PMRC_RST_WDOG_POR;
        PMRC_CAUSE_EXT: begin
          watchdog_control_q <= PMRC_RST_WDOG_EXT;
          watchdog_control_q[PMRC_BIT_WD_RESET_FLAG] <=
            watchdog_control_q[PMRC_BIT_WD_RESET_FLAG];
          watchdog_control_q[PMRC_BIT_WD_EN] <= watchdog_control_q[PMRC_BIT_WD_EN];
        end
        PMRC_CAUSE_WD: begin
          watchdog_control_q <= PMRC_RST_WDOG_WD;
          watchdog_control_q[PMRC_BIT_WD_EN] <= watchdog_control_q[PMRC_BIT_WD_EN];
        end
        default: begin
          if (wr_wdog) begin
            watchdog_control_q <= (timed_ok ?
              reg_wdata : (reg_wdata & ~PMRC_WDOG_PROTECT_MASK) |
              (watchdog_control_q & PMRC_WDOG_PROTECT_MASK)) & PMRC_WDOG_IMPL_MASK;
            watchdog_control_q[PMRC_BIT_RESTART] <= 1'b0;
          end
          // timeout flag: set wins over a clear
          if (wd_timeout && !grace_q) begin
            watchdog_control_q[PMRC_BIT_WD_IRQ_FLAG] <= 1'b1;
          end
        end
      endcase
    end
  end

  // =====================================================================
  // wake sources
  // enabled external pin and global enable
  assign ext_wake = irq_en_q[PMRC_BIT_GLOBAL_EN] &&
    ((irq_en_q[PMRC_BIT_EXT0_EN] && !ext_irq0_n) ||
     (irq_en_q[PMRC_BIT_EXT1_EN] && !ext_irq1_n));
  assign idle_wake = ext_wake || periph_irq ||
    (watchdog_control_q[PMRC_BIT_WD_IRQ_FLAG] && watchdog_control_q[PMRC_BIT_WD_EN]);

  // =====================================================================
  // power mode sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst || any_rst) begin
      mode_q <= PMRC_RUN;
      power_ctrl_q <= 2'b00;
    end else begin
      case (mode_q)
        PMRC_RUN: begin
          if (wr_power_ctrl) begin
            power_ctrl_q <= reg_wdata[1:0];
            if (reg_wdata[PMRC_BIT_PDOWN]) begin
              mode_q <= PMRC_PDOWN;
            end else if (reg_wdata[PMRC_BIT_IDLE]) begin
              mode_q <= PMRC_IDLE;
            end
          end
        end
        PMRC_IDLE: begin
          if (idle_wake) begin
            mode_q <= PMRC_RUN;
            power_ctrl_q <= 2'b00;
          end
        end
        PMRC_PDOWN: begin
          if (ext_wake) begin
            mode_q <= PMRC_RUN;
            power_ctrl_q <= 2'b00;
          end
        end
        default: mode_q <= PMRC_RUN;
      endcase
    end
  end

  // wake interrupt pulse, and skip flag for reset out of idle
  // no stray instruction after reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_irq_q <= 1'b0;
      skip_q <= 1'b0;
      core_reset_q <= 1'b1;
    end else begin
      wake_irq_q <= (mode_q == PMRC_IDLE && idle_wake) ||
        (mode_q == PMRC_PDOWN && ext_wake && !any_rst);
      skip_q <= any_rst && mode_q == PMRC_IDLE ? 1'b1 : (irq_ack ? 1'b0 : skip_q);
      // core reset while any reset holds
      core_reset_q <= any_rst || !por_done_q;
    end
  end

  // =====================================================================
  // option, enable and port registers
  // ports reset to FFh
  always_ff @(posedge ref_clk) begin
    if (sys_rst || any_rst) begin
      option_q <= 8'h00;
      irq_en_q <= 8'h00;
      port_q <= PMRC_RST_PORT;
    end else begin
      if (reg_wr && reg_addr == PMRC_ADDR_OPTION) begin
        option_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == PMRC_ADDR_IRQ_EN) begin
        irq_en_q <= reg_wdata;
      end
      if (mode_q == PMRC_RUN) begin
        port_q <= port_data;
      end
    end
  end

  // =====================================================================
  // register read, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        PMRC_ADDR_POWER_CTRL: reg_rdata_q <= {6'h00, power_ctrl_q};
        PMRC_ADDR_WDOG_CTRL: reg_rdata_q <= watchdog_control_q;
        PMRC_ADDR_OPTION: reg_rdata_q <= option_q;
        PMRC_ADDR_IRQ_EN: reg_rdata_q <= irq_en_q;
        PMRC_ADDR_STATUS: reg_rdata_q <= {4'h0, skip_q, timed_ok, mode_q};
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // =====================================================================
  // outputs
  // only cpu clock gated in idle
  assign cpu_clk_en = mode_q == PMRC_RUN;
  assign periph_clk_en = mode_q != PMRC_PDOWN;
  assign ale_out = mode_q == PMRC_PDOWN ? option_q[PMRC_BIT_STROBE_HOLD] : 1'b1;
  assign prog_store_strobe = ale_out;
  // reset values; ram is not touched here
  assign pc_load = PMRC_RST_PC;
  assign stack_init = PMRC_RST_STACK;
  assign port_out = port_q;
  assign core_reset = core_reset_q;
  assign skip_next = skip_q;
  assign wake_irq = wake_irq_q;
  assign reg_rdata = reg_rdata_q;
endmodule
`default_nettype wire

// [pmrc_top_bench.sv]
// pmrc_top_bench: scenario bench for the power mode and reset block
// assumes: pmrc_pkg, pmrc_top, pmrc_checker and pmrc_pins_model compiled first
`timescale 1ns/1ps
`default_nettype none
module pmrc_top_bench;
  import pmrc_pkg::*;
  // short timeout keeps the watchdog run brief
  localparam int WD_CYC = 256;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, port_data = 8'hFF, rst_len = 8'h00, rd_val;
  logic reg_wr = 1'b0, reg_rd = 1'b0, periph_irq = 1'b0, irq_ack = 1'b0, rst_go = 1'b0;
  logic [1:0] irq_low = 2'b00;
  logic reset_pin, ext_irq0_n, ext_irq1_n, cpu_clk_en, periph_clk_en, core_reset;
  logic skip_next, wake_irq, ale_out, prog_store_strobe;
  logic [15:0] pc_load;
  logic [7:0] stack_init, reg_rdata, port_out;
  int miscompares = 0;
  int checks = 0;
  int rst_seen = 0;
  // ==================================================================
  // structure
  pmrc_top #(.WD_TIMEOUT_CYC(WD_CYC)) u_pmrc_top (.ref_clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reset_pin, .ext_irq0_n, .ext_irq1_n, .periph_irq, .irq_ack,
    .port_data, .cpu_clk_en, .periph_clk_en, .core_reset, .pc_load, .stack_init, .skip_next,
    .wake_irq, .ale_out, .prog_store_strobe, .port_out);
  pmrc_pins_model u_pmrc_pins_model (.ref_clk, .rst_go, .rst_len, .irq_low, .reset_pin,
    .ext_irq0_n, .ext_irq1_n);
  // clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // reset cycles seen, to prove a pulse was ignored
  always @(posedge ref_clk) begin
    if (core_reset === 1'b1) rst_seen++;
  end
  // ==================================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  // two key bytes then the guarded write, no gaps
  // timed access procedure
  task automatic key_wr(input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= PMRC_ADDR_TIMED_KEY;
    reg_wdata <= PMRC_KEY_FIRST;
    @(posedge ref_clk);
    reg_wdata <= PMRC_KEY_SECOND;
    @(posedge ref_clk);
    reg_addr <= PMRC_ADDR_WDOG_CTRL;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    tick(20);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    tick(2);
  endtask
  task automatic pin_go(input logic [7:0] n);
    @(posedge ref_clk);
    rst_go <= 1'b1;
    rst_len <= n;
    @(posedge ref_clk);
    rst_go <= 1'b0;
    #1;
  endtask
  // ==================================================================
  // scenarios
  task automatic t_reset_state();
    do_reset();
    chk({pc_load}, 16'h0000);
    chk({port_out, stack_init}, 16'hFF07);
    rd(PMRC_ADDR_WDOG_CTRL);
    chk(rd_val & 8'hF7, 16'h0040);
    rd(PMRC_ADDR_POWER_CTRL);
    chk(rd_val, 16'h0000);
    wr(8'h33, 8'hA5);
    rd(8'h33);
    chk(rd_val, 16'h0000);
    $display("test reset_state done");
  endtask
  task automatic t_timed_access();
    do_reset();
    wr(PMRC_ADDR_WDOG_CTRL, 8'hFF);
    rd(PMRC_ADDR_WDOG_CTRL);
    chk(rd_val & 8'hF7, 16'h0044);
    key_wr(8'h02);
    rd(PMRC_ADDR_WDOG_CTRL);
    chk(rd_val & 8'hF7, 16'h0002);
    $display("test timed_access done");
  endtask
  task automatic t_idle();
    do_reset();
    @(posedge ref_clk);
    port_data <= 8'h5A;
    tick(2);
    wr(PMRC_ADDR_POWER_CTRL, 8'h01);
    chk({cpu_clk_en, periph_clk_en, ale_out, prog_store_strobe}, 16'h0007);
    @(posedge ref_clk);
    port_data <= 8'hC3;
    tick(3);
    chk(port_out, 16'h005A);
    @(posedge ref_clk);
    periph_irq <= 1'b1;
    tick(1);
    chk({wake_irq, cpu_clk_en}, 16'h0003);
    @(posedge ref_clk);
    periph_irq <= 1'b0;
    rd(PMRC_ADDR_POWER_CTRL);
    chk(rd_val, 16'h0000);
    chk(port_out, 16'h00C3);
    $display("test idle done");
  endtask
  // opt 0: pin 0 wakes; opt 1: pin 1 lacks global enable, reset pin exits
  task automatic t_pdown(input logic opt);
    do_reset();
    wr(PMRC_ADDR_OPTION, {5'h00, opt, 2'h0});
    wr(PMRC_ADDR_IRQ_EN, opt ? 8'h04 : 8'h81);
    wr(PMRC_ADDR_POWER_CTRL, 8'h02);
    chk({periph_clk_en, cpu_clk_en, ale_out, prog_store_strobe}, {14'h0, opt, opt});
    @(posedge ref_clk);
    periph_irq <= 1'b1;
    irq_low <= {opt, 1'b0};
    tick(3);
    chk(periph_clk_en, 16'h0000);
    @(posedge ref_clk);
    periph_irq <= 1'b0;
    irq_low <= {opt, !opt};
    tick(3);
    chk({periph_clk_en, cpu_clk_en}, {14'h0, !opt, !opt});
    @(posedge ref_clk);
    irq_low <= 2'b00;
    pin_go(8'h0A);
    tick(16);
    chk({periph_clk_en, cpu_clk_en}, 16'h0003);
    $display("test power_down done");
  endtask
  task automatic t_pin_reset();
    int n;
    int i;
    do_reset();
    wr(PMRC_ADDR_WDOG_CTRL, 8'h04);
    @(posedge ref_clk);
    port_data <= 8'h3C;
    n = rst_seen;
    pin_go(8'h07);
    tick(12);
    chk(16'(rst_seen - n), 16'h0000);
    wr(PMRC_ADDR_POWER_CTRL, 8'h01);
    pin_go(8'h0C);
    for (i = 0; i < 14 && core_reset !== 1'b1; i++) tick(1);
    tick(1);
    chk(port_out, 16'h00FF);
    tick(12);
    chk({skip_next, cpu_clk_en}, 16'h0003);
    rd(PMRC_ADDR_WDOG_CTRL);
    chk(rd_val & 8'hF7, 16'h0004);
    rd(PMRC_ADDR_POWER_CTRL);
    chk(rd_val, 16'h0000);
    @(posedge ref_clk);
    irq_ack <= 1'b1;
    @(posedge ref_clk);
    irq_ack <= 1'b0;
    tick(1);
    chk(skip_next, 16'h0000);
    $display("test pin_reset done");
  endtask
  task automatic t_watchdog();
    int n;
    int i;
    do_reset();
    n = rst_seen;
    key_wr(8'h03);
    for (i = 0; i < 8; i++) begin
      tick(120);
      key_wr(8'h03);
    end
    chk(16'(rst_seen - n), 16'h0000);
    wr(PMRC_ADDR_POWER_CTRL, 8'h01);
    for (i = 0; i < 300 && wake_irq !== 1'b1; i++) tick(1);
    chk({wake_irq, cpu_clk_en}, 16'h0003);
    for (i = 0; i < 600 && core_reset !== 1'b1; i++) tick(1);
    chk(i >= 509 && i <= 514, 16'h0001);
    for (i = 0; i < 20 && core_reset === 1'b1; i++) tick(1);
    rd(PMRC_ADDR_WDOG_CTRL);
    chk(rd_val & 8'hF7, 16'h0006);
    do_reset();
    rd(PMRC_ADDR_WDOG_CTRL);
    chk(rd_val & 8'hF7, 16'h0040);
    $display("test watchdog done");
  endtask
  // ==================================================================
  // run control
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    t_reset_state();
    t_timed_access();
    t_idle();
    t_pdown(1'b0);
    t_pdown(1'b1);
    t_pin_reset();
    t_watchdog();
    summarize();
  end
  // hang guard, several times the expected run
  initial begin
    #(40 * 20000);
    miscompares++;
    summarize();
  end
endmodule
bind pmrc_top pmrc_checker #(.WD_TIMEOUT_CYC(WD_TIMEOUT_CYC)) u_pmrc_checker (.ref_clk,
  .sys_rst, .reset_pin, .periph_irq, .irq_ack, .cpu_clk_en, .periph_clk_en, .core_reset,
  .pc_load, .stack_init, .skip_next, .wake_irq, .ale_out, .prog_store_strobe, .port_out);
`default_nettype wire
